// ### verilog/pos_cfg.svh
`ifndef POS_CFG_SVH
`define POS_CFG_SVH

// ****************************************
// Register indices and layout
// ****************************************
`define POS_INPUT_SHUTDOWN_CTRL_STATUS_IDX 32'hFFFF_83C0
`define POS_OUTPUT_COMPARE_CTRL_STATUS_IDX 32'hFFFF_83C2
`define POS_REG_RESET 16'h0000
`define POS_FLAG_LSB 12
`define POS_IRQEN_BIT 8
`define POS_MODE_W 2
`define POS_OSF_BIT 15
`define POS_OCE_BIT 9
`define POS_OIE_BIT 8

// ****************************************
// Modes and timing
// ****************************************
`define POS_MODE_EDGE 2'h0
`define POS_MODE_LOW8 2'h1
`define POS_MODE_LOW16 2'h2
`define POS_MODE_LOW128 2'h3
`define POS_DIV_A 8
`define POS_DIV_B 16
`define POS_DIV_C 128
`define POS_LOW_RUN 16
`define POS_RESP_OKAY 2'h0
`define POS_RESP_SLVERR 2'h2

`endif

// ### verilog/pos_pkg.sv
package pos_pkg;

  // Compared timer outputs, one bit per pin
  typedef struct packed {
    logic timer3OutB;
    logic timer3OutD;
    logic timer4OutA;
    logic timer4OutC;
    logic timer4OutB;
    logic timer4OutD;
  } pos_timer_out_type;

  typedef logic [1:0] pos_mode_type;

endpackage : pos_pkg

// ### verilog/pos_prescale.sv
`include "pos_cfg.svh"

module pos_prescale
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstN,
  // Sample enables: phi/8, phi/16, phi/128
  output logic [2:0] smpEn
);

  localparam int DIVS [3] = '{`POS_DIV_A, `POS_DIV_B, `POS_DIV_C};

  logic [6:0] cnt_q;

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      cnt_q <= 7'h00;
    else
      cnt_q <= cnt_q + 7'h01;
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_en
    localparam logic [6:0] MASK = 7'(DIVS[g] - 1);
    always_ff @(posedge mclk or negedge rstN)
    begin
      if (!rstN)
        smpEn[g] <= 1'b0;
      else
        smpEn[g] <= (cnt_q & MASK) == MASK; // [RULE2] [RULE3]
    end
  end

  chk_div_spacing : assert property (@(posedge mclk) disable iff (!rstN)
    smpEn[2] |=> !smpEn[2] [*8]) // [RULE3]
    else $error("phi/128 enable repeats too early");

endmodule : pos_prescale

// ### verilog/pos_in_detect.sv
`include "pos_cfg.svh"

module pos_in_detect
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstN,
  // Request pin, active low
  input  wire logic                  reqN,
  // Mode and sample enables
  input  wire pos_pkg::pos_mode_type mode,
  input  wire logic [2:0]            smpEn,
  // Accepted request pulse
  output logic                       accept
);

  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic [3:0] cnt_q;
  logic       tick;

  // Pin is asynchronous: two flops before any use
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= reqN; // [RULE20]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb
  begin
    unique case (mode)
      `POS_MODE_LOW8:  tick = smpEn[0]; // [RULE2]
      `POS_MODE_LOW16: tick = smpEn[1]; // [RULE3]
      `POS_MODE_LOW128: tick = smpEn[2]; // [RULE3]
      default:         tick = 1'b0;
    endcase
  end

  // A change between low modes does not restart the run; mode 00 holds it at zero
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      cnt_q <= 4'h0;
    else if (mode == `POS_MODE_EDGE || (tick && s2_q))
      cnt_q <= 4'h0; // [RULE16]
    else if (tick)
      cnt_q <= cnt_q + 4'h1;
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      accept <= 1'b0;
    else if (mode == `POS_MODE_EDGE)
      accept <= s3_q && !s2_q; // [RULE1]
    else
      accept <= tick && !s2_q && cnt_q == 4'(`POS_LOW_RUN - 1); // [RULE2]
  end

  chk_edge_accept : assert property (@(posedge mclk) disable iff (!rstN)
    mode == `POS_MODE_EDGE && s3_q && !s2_q |=> accept) // [RULE1]
    else $error("falling edge not accepted");
  chk_high_restart : assert property (@(posedge mclk) disable iff (!rstN)
    tick && s2_q |=> cnt_q == 4'h0) // [RULE16]
    else $error("high sample did not restart run");

endmodule : pos_in_detect

// ### verilog/pos_top.sv
// What this block does
// RULE1: Mode 00 accepts request on falling edge
// RULE2: Low modes need 16 low samples; 01 phi/8
// RULE3: Mode 10 samples phi/16, 11 phi/128
// RULE4: Mode fields bits 7:0, two per input, reset 00
// RULE5: Accepted request sets sticky flag bits 15:12
// RULE6: Flag clears by 0 write after reading 1
// RULE7: Any input flag forces all pins hi-Z
// RULE8: Bit 8 enables input interrupt while flagged
// RULE9: Bits 11:9 read zero, written zero
// RULE10: Registers reset only by power-on reset
// RULE11: Two-cycle simultaneous low pair sets short
// RULE12: Compare absent in slow variant option
// RULE13: Short flag clears by zero write only
// RULE14: Oscillator stop or standby forces hi-Z
// RULE15: Interrupts for input and output detections
// RULE16: One high sample restarts the low run
// RULE17: Short flag set; bit 9 enables compare
// RULE18: Short hi-Z and interrupt need bit 8
// RULE19: Software disables compare before clearing short
// RULE20: Request pins synchronised before detection
//
// Implementation choice: the AXI4-Lite slave port.
`include "pos_cfg.svh"

module pos_top #(
  parameter int         AW              = 16,
  parameter logic       COMPARE_PRESENT = 1'b1
)
(
  // Clock and power-on reset
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  // AXI4-Lite write
  input  wire logic [AW-1:0]             s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]             s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Request pins and compared outputs
  input  wire logic [3:0]                shutdownReqInN,
  input  wire pos_pkg::pos_timer_out_type timerOut,
  input  wire logic                      oscStopped,
  input  wire logic                      standbyMode,
  // Shutdown and interrupts
  output logic                           pinHiZ,
  output logic                           inIrq,
  output logic                           shortIrq
);

  // ****************************************
  // Reset release and addresses
  // ****************************************
  localparam logic [AW-1:0] INPUT_SHUTDOWN_CTRL_STATUS_ADDR = AW'(`POS_INPUT_SHUTDOWN_CTRL_STATUS_IDX << 2);
  localparam logic [AW-1:0] OUTPUT_COMPARE_CTRL_STATUS_ADDR = AW'(`POS_OUTPUT_COMPARE_CTRL_STATUS_IDX << 2);

  logic rstMeta_q;
  logic rstN;

  // Only the power-on pin resets state; no other reset enters here
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q; // [RULE10]
    end
  end

  function automatic logic [1:0] hitOf(input logic [AW-1:0] a);
    logic [AW-1:0] w;
    w = {a[AW-1:2], 2'b00};
    hitOf = {w == OUTPUT_COMPARE_CTRL_STATUS_ADDR, w == INPUT_SHUTDOWN_CTRL_STATUS_ADDR};
  endfunction : hitOf

  // ****************************************
  // Bus slave
  // ****************************************
  logic          awHeld_q;
  logic [AW-1:0] awAddr_q;
  logic          wHeld_q;
  logic [15:0]   wData_q;
  logic [1:0]    wStrb_q;
  logic          doWrite;
  logic [1:0]    wrHit;
  logic          rdTake;
  logic [1:0]    rdHit;
  logic [31:0]   icsrWord;
  logic [31:0]   ocsrWord;

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrHit   = hitOf(awAddr_q);
  assign rdTake  = s_axi_arvalid && s_axi_arready;
  assign rdHit   = hitOf(s_axi_araddr);

  logic          rdIcsr_q;

  // Remembers which register the pending read answers
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      rdIcsr_q <= 1'b0;
    else if (rdTake)
      rdIcsr_q <= rdHit[0];
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= '0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_q      <= 1'b1;
      awAddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      awHeld_q      <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      wHeld_q      <= 1'b0;
      wData_q      <= 16'h0000;
      wStrb_q      <= 2'h0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_q      <= 1'b1;
      wData_q      <= s_axi_wdata[15:0];
      wStrb_q      <= s_axi_wstrb[1:0];
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      wHeld_q      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `POS_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (|wrHit) ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `POS_RESP_OKAY;
    end
    else if (rdTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdHit[0] ? icsrWord : (rdHit[1] ? ocsrWord : 32'h0000_0000);
      s_axi_rresp   <= (|rdHit) ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ****************************************
  // Input level detection
  // ****************************************
  logic [7:0] modes_q;
  logic       irqEn_q;
  logic [3:0] flag_q;
  logic [3:0] seen_q;
  logic [3:0] accept;
  logic [2:0] smpEn;
  logic [3:0] flagClr;
  logic [3:0] flagD;
  logic       icsrWr;

  pos_prescale u_prescale (
    .mclk  (mclk),
    .rstN  (rstN),
    .smpEn (smpEn)
  );

  for (genvar g = 0; g < 4; g++)
  begin : g_in
    pos_in_detect u_det (
      .mclk   (mclk),
      .rstN   (rstN),
      .reqN   (shutdownReqInN[g]),
      .mode   (modes_q[`POS_MODE_W*g +: `POS_MODE_W]), // [RULE4]
      .smpEn  (smpEn),
      .accept (accept[g])
    );
  end

  assign icsrWr  = doWrite && wrHit[0];
  // Clear needs a prior read of 1; writing 1 does nothing
  assign flagClr = {4{icsrWr && wStrb_q[1]}} & ~wData_q[`POS_FLAG_LSB +: 4] & seen_q; // [RULE6]
  // A new request in the clearing cycle wins
  assign flagD   = accept | (flag_q & ~flagClr); // [RULE5]
  // Reserved bits 11:9 read as zero and are never stored
  assign icsrWord = {16'h0000, flag_q, 3'b000, irqEn_q, modes_q}; // [RULE9]

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      modes_q <= 8'h00; // [RULE10]
      irqEn_q <= 1'b0;
    end
    else if (icsrWr)
    begin
      if (wStrb_q[0])
        modes_q <= wData_q[7:0]; // [RULE4]
      if (wStrb_q[1])
        irqEn_q <= wData_q[`POS_IRQEN_BIT]; // [RULE8]
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      flag_q <= 4'h0;
      seen_q <= 4'h0;
    end
    else
    begin
      flag_q <= flagD; // [RULE5]
      seen_q <= ((seen_q & ~flagClr & ~accept) | (rdTake && rdHit[0] ? flag_q : 4'h0)) & flagD;
    end
  end

  // ****************************************
  // Output level compare
  // ****************************************
  logic oce_q;
  logic oie_q;
  logic osf_q;
  logic osfSeen_q;
  logic lowPair;
  logic lowPrev_q;
  logic ocsrWr;
  logic osfClr;
  logic shortSet;

  assign lowPair = (!timerOut.timer3OutB && !timerOut.timer3OutD)
                || (!timerOut.timer4OutA && !timerOut.timer4OutC)
                || (!timerOut.timer4OutB && !timerOut.timer4OutD); // [RULE11]
  // Low in two successive cycles means low for longer than one cycle
  assign shortSet = COMPARE_PRESENT && oce_q && lowPair && lowPrev_q; // [RULE11] [RULE12] [RULE17]
  assign ocsrWr   = doWrite && wrHit[1];
  assign osfClr   = ocsrWr && wStrb_q[1] && !wData_q[`POS_OSF_BIT] && osfSeen_q; // [RULE13]
  assign ocsrWord = {16'h0000, osf_q, 5'h00, oce_q, oie_q, 8'h00};

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      oce_q     <= 1'b0;
      oie_q     <= 1'b0;
      osf_q     <= 1'b0;
      osfSeen_q <= 1'b0;
      lowPrev_q <= 1'b0;
    end
    else
    begin
      lowPrev_q <= lowPair;
      if (ocsrWr && wStrb_q[1])
      begin
        oce_q <= wData_q[`POS_OCE_BIT] && COMPARE_PRESENT; // [RULE12] [RULE17]
        oie_q <= wData_q[`POS_OIE_BIT]; // [RULE18]
      end
      osf_q     <= shortSet || (osf_q && !osfClr); // [RULE13] [RULE17]
      osfSeen_q <= (osfSeen_q && !osfClr && !shortSet) || (rdTake && rdHit[1] && osf_q);
    end
  end

  // ****************************************
  // Shutdown and interrupt outputs
  // ****************************************
  // Stopped clock cannot clock this flop; the clock unit must gate that case too
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinHiZ   <= 1'b0;
      inIrq    <= 1'b0;
      shortIrq <= 1'b0;
    end
    else
    begin
      pinHiZ   <= (|flag_q) || (osf_q && oce_q && oie_q) // [RULE7] [RULE18]
               || oscStopped || standbyMode; // [RULE14]
      inIrq    <= irqEn_q && (|flag_q); // [RULE8] [RULE15]
      shortIrq <= osf_q && oce_q && oie_q; // [RULE15] [RULE18]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_flag_set : assert property (@(posedge mclk) disable iff (!rstN)
    |accept |=> (flag_q & $past(accept)) == $past(accept)) // [RULE5]
    else $error("accepted request did not set flag");
  chk_clear_read : assert property (@(posedge mclk) disable iff (!rstN)
    $fell(flag_q[0]) |-> $past(seen_q[0]) && $past(icsrWr)) // [RULE6]
    else $error("flag cleared without prior read");
  chk_hiz_hold : assert property (@(posedge mclk) disable iff (!rstN)
    |flag_q |=> pinHiZ) // [RULE7]
    else $error("input flag set but pins not hi-Z");
  chk_in_irq : assert property (@(posedge mclk) disable iff (!rstN)
    ##1 inIrq == ($past(irqEn_q) && (|$past(flag_q)))) // [RULE8]
    else $error("input interrupt mismatch");
  chk_rsv_zero : assert property (@(posedge mclk) disable iff (!rstN)
    s_axi_rvalid && rdIcsr_q |-> s_axi_rdata[11:9] == 3'h0) // [RULE9]
    else $error("reserved bits read nonzero");
  chk_short_set : assert property (@(posedge mclk) disable iff (!rstN)
    oce_q && lowPair && $past(lowPair) |=> osf_q) // [RULE11]
    else $error("short pair not flagged");
  chk_short_gate : assert property (@(posedge mclk) disable iff (!rstN)
    !oie_q && !(|flag_q) && !oscStopped && !standbyMode |=> !shortIrq && !pinHiZ) // [RULE18]
    else $error("short acted with its enable off");
  chk_osc_hiz : assert property (@(posedge mclk) disable iff (!rstN)
    oscStopped || standbyMode |=> pinHiZ) // [RULE14]
    else $error("clock stop did not force hi-Z");

  cov_edge : cover property (@(posedge mclk) disable iff (!rstN) accept[0] ##1 flag_q[0]);
  cov_short : cover property (@(posedge mclk) disable iff (!rstN) shortSet && oie_q);
  cov_clear : cover property (@(posedge mclk) disable iff (!rstN) |flagClr);
  cov_race : cover property (@(posedge mclk) disable iff (!rstN) |(flagClr & accept));

endmodule : pos_top

// ### verif/pos_fault_partner.sv
module pos_fault_partner
(
  // Clock and commands
  input  wire logic                      mclk,
  input  wire logic [3:0]                reqActive,
  input  wire logic [2:0]                pairLow,
  input  wire logic                      allHigh,
  // Lines into the block
  output logic [3:0]                     shutdownReqInN,
  output pos_pkg::pos_timer_out_type     timerOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Fault sources and timer pairs
  // ****************************************
  logic [3:0] phase_q = 4'h0;
  logic [5:0] outBits;

  always_ff @(posedge mclk)
    phase_q <= phase_q + 4'h1;

  // Open-drain sources: an idle line sits at its pull-up
  assign shutdownReqInN = ~reqActive;

  // Healthy pairs run complementary, so they never overlap low
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      outBits[5-2*p -: 2] = allHigh ? 2'b11 :
                            pairLow[p] ? 2'b00 : {phase_q[3], ~phase_q[3]};
    end
  end

  assign timerOut = outBits;
endmodule : pos_fault_partner

// ### verif/tb_port_output_shutdown.sv
`include "pos_cfg.svh"

module tb_port_output_shutdown;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  localparam logic [15:0] INPUT_SHUTDOWN_CTRL_STATUS_A = 16'h0f00;
  localparam logic [15:0] OUTPUT_COMPARE_CTRL_STATUS_A = 16'h0f08;
  localparam logic [15:0] BAD_A  = 16'h0f04;

  logic                       mclk;
  logic                       nrst;
  logic [15:0]                s_axi_awaddr;
  logic [15:0]                s_axi_araddr;
  logic [31:0]                s_axi_wdata;
  logic [31:0]                s_axi_rdata;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp;
  logic [1:0]                 s_axi_rresp;
  logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready;
  logic [3:0]                 reqActive;
  logic [3:0]                 shutdownReqInN;
  logic [2:0]                 pairLow;
  logic                       allHigh, oscStopped, standbyMode, pinHiZ, inIrq, shortIrq;
  pos_pkg::pos_timer_out_type timerOut;
  int                         fails, nCompared, seed;

  pos_top u_pos_top (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shutdownReqInN,
    .timerOut, .oscStopped, .standbyMode, .pinHiZ, .inIrq, .shortIrq);

  pos_fault_partner u_pos_fault_partner (.mclk, .reqActive, .pairLow, .allHigh,
    .shutdownReqInN, .timerOut);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] exp_resp(input logic [15:0] a);
    return (a == INPUT_SHUTDOWN_CTRL_STATUS_A || a == OUTPUT_COMPARE_CTRL_STATUS_A) ? 32'(`POS_RESP_OKAY) : 32'(`POS_RESP_SLVERR);
  endfunction : exp_resp

  function automatic int div_of(input int m);
    return (m == 1) ? `POS_DIV_A : (m == 2) ? `POS_DIV_B : `POS_DIV_C;
  endfunction : div_of

  function automatic logic [15:0] flag_of(input int n);
    return 16'h1000 << n;
  endfunction : flag_of

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge mclk);
      if (s_axi_awready)
        aw = 1'b1;
      if (s_axi_wready)
        w = 1'b1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, exp_resp(a));
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, {16'h0000, e});
    chk(s_axi_rresp, exp_resp(a));
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic complete_run();
    $display("Compared %0d, failed %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // Longest scenario is the slow sampling mode, well below this
  initial
  begin
    repeat (40000) @(posedge mclk);
    fails++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    int n;
    int dv;
    logic [15:0] d;
    logic [15:0] md;
    logic [15:0] oc;
    logic output_short_irq_enable;
    seed = 32'h67b8_4402;
    fails = 0;
    nCompared = 0;
    nrst = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {reqActive, pairLow, allHigh, oscStopped, standbyMode} = '0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0000);
    rd(OUTPUT_COMPARE_CTRL_STATUS_A, 16'h0000);
    repeat (4)
    begin
      d = 16'($random(seed));
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, d & 16'hf1ff);
      rd(INPUT_SHUTDOWN_CTRL_STATUS_A, d & 16'h01ff);
    end
    wr(BAD_A, 16'hffff);
    rd(BAD_A, 16'h0000);
    // Falling edge; a clear before any read must not take
    for (n = 0; n < 4; n++)
    begin
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0100);
      reqActive[n] <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(pinHiZ, 1'b1);
      chk(inIrq, 1'b1);
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0100);
      reqActive[n] <= 1'b0;
      rd(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0100 | flag_of(n));
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0100);
      repeat (2) @(posedge mclk);
      chk(pinHiZ, 1'b0);
      chk(inIrq, 1'b0);
    end
    // Low-level runs: a short run fails, a full run of 16 ticks wins
    for (int m = 1; m < 4; m++)
    begin
      n = $unsigned($random(seed)) % 4;
      dv = div_of(m);
      md = 16'(m) << (2 * n);
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'hf000 | md);
      rd(INPUT_SHUTDOWN_CTRL_STATUS_A, md);
      reqActive[n] <= 1'b1;
      repeat (15 * dv - 1) @(posedge mclk);
      reqActive[n] <= 1'b0;
      repeat (2 * dv) @(posedge mclk);
      chk(pinHiZ, 1'b0);
      reqActive[n] <= 1'b1;
      repeat (15 * dv - 1) @(posedge mclk);
      chk(pinHiZ, 1'b0);
      repeat (2 * dv + 8) @(posedge mclk);
      chk(pinHiZ, 1'b1);
      chk(inIrq, 1'b0);
      reqActive[n] <= 1'b0;
      rd(INPUT_SHUTDOWN_CTRL_STATUS_A, md | flag_of(n));
      wr(INPUT_SHUTDOWN_CTRL_STATUS_A, md);
      // Let a high tick restart the run before the mode changes
      repeat (2 * dv) @(posedge mclk);
      chk(pinHiZ, 1'b0);
    end
    // Output pairs: a one-cycle low is tolerated, a three-cycle low is not
    for (int p = 0; p < 3; p++)
    begin
      output_short_irq_enable = (p != 1);
      oc = 16'h0200 | (16'(output_short_irq_enable) << 8);
      wr(OUTPUT_COMPARE_CTRL_STATUS_A, oc);
      pairLow[p] <= 1'b1;
      @(posedge mclk);
      pairLow[p] <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(pinHiZ, 1'b0);
      rd(OUTPUT_COMPARE_CTRL_STATUS_A, oc);
      pairLow[p] <= 1'b1;
      repeat (3) @(posedge mclk);
      pairLow[p] <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(pinHiZ, output_short_irq_enable);
      chk(shortIrq, output_short_irq_enable);
      rd(OUTPUT_COMPARE_CTRL_STATUS_A, oc | 16'h8000);
      allHigh <= 1'b1;
      wr(OUTPUT_COMPARE_CTRL_STATUS_A, 16'h8000 | (16'(output_short_irq_enable) << 8));
      wr(OUTPUT_COMPARE_CTRL_STATUS_A, 16'(output_short_irq_enable) << 8);
      rd(OUTPUT_COMPARE_CTRL_STATUS_A, 16'(output_short_irq_enable) << 8);
      chk(pinHiZ, 1'b0);
      allHigh <= 1'b0;
    end
    for (int i = 0; i < 2; i++)
    begin
      {standbyMode, oscStopped} <= (i == 0) ? 2'b01 : 2'b10;
      repeat (3) @(posedge mclk);
      chk(pinHiZ, 1'b1);
      {standbyMode, oscStopped} <= 2'b00;
      repeat (3) @(posedge mclk);
      chk(pinHiZ, 1'b0);
    end
    wr(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0155);
    wr(OUTPUT_COMPARE_CTRL_STATUS_A, 16'h0300);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(INPUT_SHUTDOWN_CTRL_STATUS_A, 16'h0000);
    rd(OUTPUT_COMPARE_CTRL_STATUS_A, 16'h0000);
    complete_run();
  end
endmodule : tb_port_output_shutdown
